// *** hdl/audio_power_ctrl.sv ***
/*
 * Audio subsystem power enable, reset sequencing, register window gating
 * and shared microphone pin control.
 * Assumes the register port is arbitrated outside and runs on ref_clk;
 * regulator power-good reports and microphone data pins are asynchronous.
 */
`timescale 1ns/1ps

// How it works
// - Analog supply regulator enable is bit 0 of register 0xA06F.
// - Digital supply regulator enable is bit 0 of register 0xA06E.
// - Supply power-up automatically holds then releases the audio digital reset.
// - Soft reset bit in 0xA038 re-runs the reset hold on demand.
// - Enable bit in 0xA038 gates audio; disabled means clock and bias off.
// - Disabled audio blocks register access, stops clock, keeps stored values.
// - Audio window contents clear whenever the digital supply is not good.
// - Bias pins double as microphone clock and select; inputs as data.
// - Two microphone data pins, each mono or stereo, up to four microphones.
// - Audio registers occupy 240 bytes from base 0xA100.
module audio_power_ctrl
    import audio_pwr_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Register port
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata_r,
    output logic             reg_ack_r,
    // Regulators
    input  supply_type       supply_good,
    output supply_type       supply_en_r,
    // Audio core control
    output logic             audio_clock_en_r,
    output logic [1:0]       audio_clock_div_r,
    output logic             audio_reset_n_r,
    // Shared microphone pins
    input  wire logic        digital_mic_data_first,
    input  wire logic        digital_mic_data_second,
    output logic             left_mic_bias_out_r,
    output logic             right_mic_bias_out_r,
    output logic             digital_mic_clock_out,
    output logic             digital_mic_clock_oe_r,
    output logic             digital_mic_select_out_r,
    output logic             digital_mic_select_oe_r,
    // Captured microphone bits
    output mic_sample_type   mic_sample,
    output logic             mic_sample_valid
);

    localparam int HOLD_LO = 1;
    localparam int HOLD_HI = RST_HOLD_CYC + 1;

    supply_type     supply_meta_r;
    supply_type     supply_s_r;
    logic [1:0]     mic_meta_r;
    logic [1:0]     mic_s_r;
    logic [7:0]     clk_cfg_r;
    logic [7:0]     ctrl_r;
    logic [7:0]     dsup_r;
    logic [7:0]     asup_r;
    logic           soft_rst_r;
    logic [7:0]     win_r [0:WIN_DEPTH-1];
    logic [7:0]     rd_data;
    logic [7:0]     mic_ctrl;
    logic           mic_dig;
    logic           power_ok;
    seq_state_type  state_r;
    seq_state_type  state_nxt;
    logic [7:0]     hold_cnt_r;
    logic [7:0]     low_cnt_r;

    // Audio window hit
    function automatic logic in_window(input logic [15:0] addr);
        return (addr >= WIN_BASE) && (addr < WIN_BASE + WIN_SIZE);
    endfunction

    // Byte index inside the audio window
    function automatic logic [7:0] win_index(input logic [15:0] addr);
        logic [15:0] ofs;
        ofs = addr - WIN_BASE;
        return ofs[7:0];
    endfunction

    // Two-stage synchronisers for regulator reports and data pins
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            supply_meta_r <= '0;
            supply_s_r    <= '0;
            mic_meta_r    <= 2'b00;
            mic_s_r       <= 2'b00;
        end else begin
            supply_meta_r <= supply_good;
            supply_s_r    <= supply_meta_r;
            mic_meta_r    <= {digital_mic_data_first, digital_mic_data_second};
            mic_s_r       <= mic_meta_r;
        end
    end

    // Power control registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_cfg_r <= REG_RESET;
            ctrl_r    <= REG_RESET;
            dsup_r    <= REG_RESET;
            asup_r    <= REG_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                CLK_CFG_ADDR: clk_cfg_r <= reg_wdata;
                ASUP_ADDR:    asup_r <= reg_wdata;
                DSUP_ADDR:    dsup_r <= reg_wdata;
                CTRL_ADDR: begin
                    ctrl_r               <= reg_wdata;
                    ctrl_r[CTRL_RST_BIT] <= 1'b0;      // Action bit, never stored
                end
                default: ;
            endcase
        end
    end

    // Soft reset request pulse
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= reg_wr && (reg_addr == CTRL_ADDR) && reg_wdata[CTRL_RST_BIT];
        end
    end

    // Audio window storage; cleared while the digital supply is down
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < WIN_DEPTH; i++) begin
                win_r[i] <= REG_RESET;
            end
        end else if (!supply_s_r.digital) begin
            for (int i = 0; i < WIN_DEPTH; i++) begin
                win_r[i] <= REG_RESET;
            end
        end else if (reg_wr && in_window(reg_addr) && audio_clock_en_r) begin
            win_r[win_index(reg_addr)] <= reg_wdata;
        end
    end

    // Read multiplexer
    always_comb begin
        rd_data = BLOCKED_READ;
        if (in_window(reg_addr)) begin
            if (audio_clock_en_r) begin
                rd_data = win_r[win_index(reg_addr)];
            end
        end else begin
            case (reg_addr)
                CLK_CFG_ADDR: rd_data = clk_cfg_r;
                CTRL_ADDR: begin
                    rd_data                 = ctrl_r;
                    rd_data[CTRL_READY_BIT] = audio_reset_n_r;
                end
                ASUP_ADDR: begin
                    rd_data               = asup_r;
                    rd_data[SUP_GOOD_BIT] = supply_s_r.analog;
                end
                DSUP_ADDR: begin
                    rd_data               = dsup_r;
                    rd_data[SUP_GOOD_BIT] = supply_s_r.digital;
                end
                default: rd_data = 8'h00;
            endcase
        end
    end

    // Read data and acknowledge one cycle after the request
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_r <= 8'h00;
            reg_ack_r   <= 1'b0;
        end else begin
            reg_ack_r <= reg_rd || reg_wr;
            if (reg_rd) begin
                reg_rdata_r <= rd_data;
            end
        end
    end

    // Both regulators enabled and reporting good
    assign power_ok = supply_s_r.analog && supply_s_r.digital && asup_r[SUP_EN_BIT] && dsup_r[SUP_EN_BIT];

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SEQ_OFF: begin
                if (asup_r[SUP_EN_BIT] && dsup_r[SUP_EN_BIT]) begin
                    state_nxt = SEQ_WAIT;
                end
            end
            SEQ_WAIT: begin
                if (power_ok && ctrl_r[CTRL_EN_BIT]) begin
                    state_nxt = SEQ_HOLD;
                end
            end
            SEQ_HOLD: begin
                if (!power_ok || !ctrl_r[CTRL_EN_BIT]) begin
                    state_nxt = SEQ_WAIT;
                end else if (hold_cnt_r == RST_HOLD_CNT - 8'h01 && !soft_rst_r) begin
                    state_nxt = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                if (!power_ok || !ctrl_r[CTRL_EN_BIT]) begin
                    state_nxt = SEQ_WAIT;
                end else if (soft_rst_r) begin
                    state_nxt = SEQ_HOLD;
                end
            end
            default: state_nxt = SEQ_OFF;
        endcase
        if (!asup_r[SUP_EN_BIT] || !dsup_r[SUP_EN_BIT]) begin
            state_nxt = SEQ_OFF;
        end
    end

    // Sequencer state and hold counter
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r    <= SEQ_OFF;
            hold_cnt_r <= 8'h00;
        end else begin
            state_r    <= state_nxt;
            // A soft reset during the hold restarts the count so the pulse is never lost
            hold_cnt_r <= (state_r == SEQ_HOLD && state_nxt == SEQ_HOLD && !soft_rst_r) ? hold_cnt_r + 8'h01 : 8'h00;
        end
    end

    // Supply enables, audio clock gate, divider and reset
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            supply_en_r       <= '0;
            audio_clock_en_r  <= 1'b0;
            audio_clock_div_r <= 2'b00;
            audio_reset_n_r   <= 1'b0;
        end else begin
            supply_en_r.analog  <= asup_r[SUP_EN_BIT];
            supply_en_r.digital <= dsup_r[SUP_EN_BIT];
            audio_clock_en_r    <= (state_nxt == SEQ_HOLD) || (state_nxt == SEQ_RUN);
            audio_clock_div_r   <= clk_cfg_r[CLK_DIV_LSB +: 2];
            audio_reset_n_r     <= (state_nxt == SEQ_RUN);
        end
    end

    assign mic_ctrl = win_r[MIC_CTRL_OFS];
    assign mic_dig  = mic_ctrl[MIC_DIG_BIT];

    // Pin sharing: analog bias or digital microphone drive, never both
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            left_mic_bias_out_r      <= 1'b0;
            right_mic_bias_out_r     <= 1'b0;
            digital_mic_clock_oe_r   <= 1'b0;
            digital_mic_select_oe_r  <= 1'b0;
            digital_mic_select_out_r <= 1'b0;
        end else begin
            left_mic_bias_out_r      <= audio_clock_en_r && !mic_dig;
            right_mic_bias_out_r     <= audio_clock_en_r && !mic_dig;
            digital_mic_clock_oe_r   <= audio_clock_en_r && mic_dig;
            digital_mic_select_oe_r  <= audio_clock_en_r && mic_dig;
            digital_mic_select_out_r <= mic_dig && mic_ctrl[MIC_SEL_BIT];
        end
    end

    // Microphone clock and capture, running only out of reset
    mic_port u_mic (
        .ref_clk       (ref_clk),
        .reset_n       (reset_n),
        .run           (audio_reset_n_r && mic_dig),
        .div_sel       (audio_clock_div_r),
        .stereo_first  (mic_ctrl[MIC_ST1_BIT]),
        .stereo_second (mic_ctrl[MIC_ST2_BIT]),
        .data_first    (mic_s_r[1]),
        .data_second   (mic_s_r[0]),
        .sample_r      (mic_sample),
        .clk_out_r     (digital_mic_clock_out),
        .valid_r       (mic_sample_valid)
    );

    // Cycles spent in reset with the audio clock running
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            low_cnt_r <= 8'h00;
        end else if (audio_clock_en_r && !audio_reset_n_r) begin
            low_cnt_r <= (low_cnt_r == 8'hFF) ? low_cnt_r : low_cnt_r + 8'h01;
        end else begin
            low_cnt_r <= 8'h00;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_clock_starts;
        $rose(audio_clock_en_r);
    endsequence

    sequence s_release;
        audio_reset_n_r || !audio_clock_en_r;
    endsequence

    a_analog_supply_follow: assert property ((reg_wr && reg_addr == ASUP_ADDR) |=> ##1
        supply_en_r.analog == $past(reg_wdata[SUP_EN_BIT], 2))
        else $error("analog supply enable does not follow its register");
    a_digital_supply_follow: assert property ((reg_wr && reg_addr == DSUP_ADDR) |=> ##1
        supply_en_r.digital == $past(reg_wdata[SUP_EN_BIT], 2))
        else $error("digital supply enable does not follow its register");
    a_reset_hold_min: assert property ($rose(audio_reset_n_r) |-> low_cnt_r >= RST_HOLD_CNT)
        else $error("audio reset released too early");
    a_auto_release: assert property (s_clock_starts |-> ##[HOLD_LO:HOLD_HI] s_release)
        else $error("audio reset not released after power up");
    a_soft_reset_drop: assert property ((reg_wr && reg_addr == CTRL_ADDR && reg_wdata[CTRL_RST_BIT])
        |=> ##1 !audio_reset_n_r ##1 !audio_reset_n_r)
        else $error("soft reset did not assert audio reset");
    a_disable_low_power: assert property (!ctrl_r[CTRL_EN_BIT] [*2] |=>
        !audio_clock_en_r && !left_mic_bias_out_r && !digital_mic_clock_oe_r)
        else $error("disabled audio not in low power");
    a_blocked_write_keeps: assert property ((reg_wr && reg_addr == WIN_BASE && !audio_clock_en_r
        && supply_s_r.digital) |=> $stable(mic_ctrl))
        else $error("blocked window write changed storage");
    a_regs_lost: assert property (!supply_s_r.digital |=> mic_ctrl == REG_RESET)
        else $error("audio registers survived supply loss");
    a_pin_share: assert property ((audio_clock_en_r && mic_dig) |=>
        digital_mic_clock_oe_r && !left_mic_bias_out_r && !right_mic_bias_out_r)
        else $error("shared pin drives bias in digital mode");
    a_window_read: assert property ((reg_rd && reg_addr == WIN_BASE && audio_clock_en_r)
        |=> reg_ack_r && reg_rdata_r == $past(mic_ctrl))
        else $error("window base read returned wrong byte");
    a_blocked_read: assert property ((reg_rd && in_window(reg_addr) && !audio_clock_en_r)
        |=> reg_ack_r && reg_rdata_r == BLOCKED_READ)
        else $error("blocked window read not fixed value");
    a_reset_needs_power: assert property (audio_reset_n_r |-> audio_clock_en_r && $past(power_ok))
        else $error("audio reset released without power and clock");

endmodule

// *** hdl/audio_pwr_pkg.sv ***
/*
 * Constants and types shared by the audio power, reset and microphone pin logic.
 * Assumes a 100 MHz reference clock and the shared 16-bit register address space.
 */
package audio_pwr_pkg;

    // Register addresses in the controller address space
    localparam logic [15:0] CLK_CFG_ADDR = 16'hA037;
    localparam logic [15:0] CTRL_ADDR    = 16'hA038;
    localparam logic [15:0] DSUP_ADDR    = 16'hA06E;
    localparam logic [15:0] ASUP_ADDR    = 16'hA06F;
    localparam logic [15:0] WIN_BASE     = 16'hA100;
    localparam logic [15:0] WIN_SIZE     = 16'h00F0;
    localparam int          WIN_DEPTH    = 240;

    // Offset of the microphone pin-mode byte inside the audio window
    localparam logic [7:0]  MIC_CTRL_OFS = 8'h00;

    // Field positions
    localparam int SUP_EN_BIT     = 0;
    localparam int SUP_GOOD_BIT   = 1;
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_RST_BIT   = 1;
    localparam int CTRL_READY_BIT = 7;
    localparam int CLK_DIV_LSB    = 0;
    localparam int MIC_DIG_BIT    = 0;
    localparam int MIC_ST1_BIT    = 1;
    localparam int MIC_ST2_BIT    = 2;
    localparam int MIC_SEL_BIT    = 3;

    // Reset and fixed read values
    localparam logic [7:0] REG_RESET    = 8'h00;
    localparam logic [7:0] BLOCKED_READ = 8'h00;

    // Timing: reset hold and microphone clock half period, rounded up
    localparam int         CLK_PERIOD_PS = 10000;
    localparam int         RST_HOLD_NS   = 1000;
    localparam int         RST_HOLD_CYC  = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] RST_HOLD_CNT  = 8'(RST_HOLD_CYC);
    localparam int         MIC_HALF_NS   = 200;
    localparam int         MIC_HALF_CYC  = (MIC_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] MIC_HALF_CNT  = 8'(MIC_HALF_CYC);

    // Power sequencer states
    typedef enum {SEQ_OFF, SEQ_WAIT, SEQ_HOLD, SEQ_RUN} seq_state_type;

    // Regulator enables or power-good reports
    typedef struct packed {
        logic analog;
        logic digital;
    } supply_type;

    // Microphone bits per data pin: [1] high-phase channel, [0] low-phase channel
    typedef struct packed {
        logic [1:0] first;
        logic [1:0] second;
    } mic_sample_type;

endpackage

// *** hdl/mic_port.sv ***
/*
 * Digital microphone clock generator and two-pin data capture.
 * Assumes data inputs are already synchronised to ref_clk.
 */
`timescale 1ns/1ps
module mic_port
    import audio_pwr_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    // Control
    input  wire logic       run,
    input  wire logic [1:0] div_sel,
    input  wire logic       stereo_first,
    input  wire logic       stereo_second,
    // Synchronised data pins
    input  wire logic       data_first,
    input  wire logic       data_second,
    // Clock pin and captured bits
    output mic_sample_type  sample_r,
    output logic            clk_out_r,
    output logic            valid_r
);

    logic [7:0]     half_cnt_r;
    logic [7:0]     half_len;
    logic           edge_now;
    logic [1:0]     hi_r;

    // Half period stretched by the configured clock divider
    assign half_len = MIC_HALF_CNT << div_sel;
    assign edge_now = run && (half_cnt_r >= half_len - 8'h01);

    // Clock divider; the pin parks low while stopped
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            half_cnt_r <= 8'h00;
            clk_out_r  <= 1'b0;
        end else if (!run) begin
            half_cnt_r <= 8'h00;
            clk_out_r  <= 1'b0;
        end else if (edge_now) begin
            half_cnt_r <= 8'h00;
            clk_out_r  <= !clk_out_r;
        end else begin
            half_cnt_r <= half_cnt_r + 8'h01;
        end
    end

    // High-phase bit taken before the fall, pair completed before the rise
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hi_r     <= 2'b00;
            sample_r <= '0;
            valid_r  <= 1'b0;
        end else begin
            valid_r <= 1'b0;
            if (edge_now && clk_out_r) begin
                hi_r <= {data_first, data_second};
            end
            if (edge_now && !clk_out_r) begin
                sample_r.first  <= {hi_r[1], stereo_first && data_first};
                sample_r.second <= {hi_r[0], stereo_second && data_second};
                valid_r         <= 1'b1;
            end
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_mono_low_zero: assert property ((edge_now && !clk_out_r && !stereo_first) |=> valid_r && !sample_r.first[0])
        else $error("mono pin produced a low-phase bit");
    a_clock_parked: assert property (!run |=> !clk_out_r ##1 (!clk_out_r || run))
        else $error("microphone clock runs while stopped");

endmodule

// *** tb/audio_power_ctrl_tb.sv ***
/*
 * Self-checking bench for audio_power_ctrl: supply enables, power-up and soft
 * reset holds, window gating, retention, power loss and microphone pins.
 * Assumes the package constants and the one-cycle register acknowledge.
 */
`timescale 1ns/1ps
module audio_power_ctrl_tb;
    import audio_pwr_pkg::*;
    logic           ref_clk = 1'b0;
    logic           reset_n = 1'b0;
    logic [15:0]    reg_addr = 16'h0000;
    logic           reg_wr = 1'b0;
    logic           reg_rd = 1'b0;
    logic [7:0]     reg_wdata = 8'h00;
    logic [7:0]     reg_rdata_r;
    logic           reg_ack_r;
    supply_type     supply_good = 2'b00;
    supply_type     supply_en_r;
    logic           audio_clock_en_r;
    logic [1:0]     audio_clock_div_r;
    logic           audio_reset_n_r;
    logic           data_first = 1'b0;
    logic           data_second = 1'b0;
    logic           clk_oe;
    logic           bias_l;
    logic           bias_r;
    logic           sel_out;
    logic           sel_oe;
    logic           mic_clk;
    mic_sample_type mic_sample;
    logic           mic_valid;
    logic [7:0]     d;
    int             n;
    int             err_count = 0;
    int             samples_checked = 0;
    int             cycles = 0;

    // Reference clock, 100 MHz
    always #5 ref_clk = ~ref_clk;

    audio_power_ctrl uut (
        .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .reg_ack_r(reg_ack_r),
        .supply_good(supply_good), .supply_en_r(supply_en_r), .audio_clock_en_r(audio_clock_en_r),
        .audio_clock_div_r(audio_clock_div_r), .audio_reset_n_r(audio_reset_n_r),
        .digital_mic_data_first(data_first), .digital_mic_data_second(data_second),
        .left_mic_bias_out_r(bias_l), .right_mic_bias_out_r(bias_r), .digital_mic_clock_out(mic_clk),
        .digital_mic_clock_oe_r(clk_oe), .digital_mic_select_out_r(sel_out),
        .digital_mic_select_oe_r(sel_oe), .mic_sample(mic_sample), .mic_sample_valid(mic_valid));

    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One register cycle; acknowledge is due one edge after the strobe
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] wd);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= wd;
        reg_wr <= w;
        reg_rd <= ~w;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        chk({7'h00, reg_ack_r}, 8'h01);
        d = reg_rdata_r;
    endtask

    task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        chk(d, exp);
    endtask

    // Bounded wait for the audio clock gate
    task automatic wait_clk_en();
        for (n = 0; n < 50 && audio_clock_en_r !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
        end
    endtask

    task automatic t_reset();
        chk({5'h00, supply_en_r, audio_reset_n_r}, 8'h00);
        rdc(ASUP_ADDR, REG_RESET);
        rdc(DSUP_ADDR, REG_RESET);
        rdc(CTRL_ADDR, REG_RESET);
        rdc(CLK_CFG_ADDR, REG_RESET);
        $display("reset test done");
    endtask

    task automatic t_power();
        acc(1'b1, CLK_CFG_ADDR, 8'h01);
        acc(1'b1, ASUP_ADDR, 8'h01);
        chk({6'h00, audio_clock_div_r}, 8'h01);
        @(posedge ref_clk);
        #1;
        chk({7'h00, supply_en_r.analog}, 8'h01);
        acc(1'b1, DSUP_ADDR, 8'h01);
        @(posedge ref_clk);
        #1;
        chk({6'h00, supply_en_r}, 8'h03);
        rdc(ASUP_ADDR, 8'h03);
        acc(1'b1, WIN_BASE, 8'h0D);
        rdc(WIN_BASE, BLOCKED_READ);
        acc(1'b1, CTRL_ADDR, 8'h01);
        wait_clk_en();
        chk({7'h00, audio_reset_n_r}, 8'h00);
        for (n = 0; n < 300 && audio_reset_n_r !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
        end
        chk(8'(n), 8'(RST_HOLD_CYC));
        rdc(CTRL_ADDR, 8'h81);
        $display("power-up test done");
    endtask

    task automatic t_soft();
        acc(1'b1, CTRL_ADDR, 8'h03);
        for (n = 0; n < 5 && audio_reset_n_r !== 1'b0; n++) begin
            @(posedge ref_clk);
            #1;
        end
        chk({7'h00, audio_reset_n_r}, 8'h00);
        for (n = 0; n < 300 && audio_reset_n_r !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
        end
        chk(8'(n), 8'(RST_HOLD_CYC));
        chk({6'h00, supply_en_r}, 8'h03);
        $display("soft reset test done");
    endtask

    task automatic t_mic();
        @(posedge ref_clk);
        data_first <= 1'b1;
        data_second <= 1'b1;
        acc(1'b1, WIN_BASE, 8'h0D);
        rdc(WIN_BASE, 8'h0D);
        acc(1'b1, WIN_BASE + 16'h00EF, 8'h5A);
        rdc(WIN_BASE + 16'h00EF, 8'h5A);
        rdc(WIN_BASE + WIN_SIZE, 8'h00);
        chk({5'h00, clk_oe, sel_oe, sel_out}, 8'h07);
        chk({6'h00, bias_l, bias_r}, 8'h00);
        for (n = 0; n < 200 && mic_clk !== 1'b0; n++) begin
            @(posedge ref_clk);
            #1;
        end
        for (n = 0; n < 200 && mic_clk !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
        end
        for (n = 0; n < 200 && mic_clk !== 1'b0; n++) begin
            @(posedge ref_clk);
            #1;
        end
        chk(8'(n), 8'(MIC_HALF_CYC * 2));
        for (n = 0; n < 200 && mic_valid !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
        end
        chk(8'(n), 8'(MIC_HALF_CYC * 2));
        chk({4'h0, mic_sample}, 8'h0B);
        $display("microphone test done");
    endtask

    task automatic t_disable();
        acc(1'b1, CTRL_ADDR, 8'h00);
        @(posedge ref_clk);
        #1;
        chk({6'h00, audio_clock_en_r, audio_reset_n_r}, 8'h00);
        rdc(WIN_BASE, BLOCKED_READ);
        acc(1'b1, WIN_BASE, 8'hFF);
        acc(1'b1, CTRL_ADDR, 8'h01);
        wait_clk_en();
        rdc(WIN_BASE, 8'h0D);
        acc(1'b1, WIN_BASE, 8'h00);
        @(posedge ref_clk);
        #1;
        chk({4'h0, bias_l, bias_r, clk_oe, sel_oe}, 8'h0C);
        $display("disable test done");
    endtask

    task automatic t_loss();
        @(posedge ref_clk);
        supply_good <= 2'b10;
        repeat (5) @(posedge ref_clk);
        #1;
        chk({6'h00, audio_clock_en_r, audio_reset_n_r}, 8'h00);
        @(posedge ref_clk);
        supply_good <= 2'b11;
        wait_clk_en();
        rdc(WIN_BASE, REG_RESET);
        $display("power loss test done");
    endtask

    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset();
        @(posedge ref_clk);
        supply_good <= 2'b11;
        t_power();
        t_soft();
        t_mic();
        t_disable();
        t_loss();
        end_of_test();
    end
endmodule
